// ===== logic/asm_map.vh
// register map and field positions for the alarm status and mask block
`ifndef ASM_MAP_VH
`define ASM_MAP_VH
`define ASM_IDX_ALARM 12'h02c0
`define ASM_IDX_STATUS 12'h02c1
`define ASM_IDX_MASK 12'h02c2
`define ASM_MASK_RESET 8'h1f
`define ASM_STATUS_RESET 8'h1f
`define ASM_BIT_LOCK 4
`define ASM_BIT_LINK 3
`define ASM_BIT_REALIGN 2
`define ASM_BIT_OSC 1
`define ASM_BIT_DIVIDER 0
`define ASM_STATUS_USED 8'h1d
`define ASM_MASK_USED 8'h1f
`endif

// ===== logic/asm_sync.v
// two-flop synchroniser for one level
`timescale 1ns/100ps
module asm_sync (
    input wire pclk, // clock
    input wire presetn, // async reset, active low
    input wire din, // asynchronous level
    output reg dout // synchronised level
);
    reg meta_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule // asm_sync

// ===== logic/asm_alarm_top.v
// alarm status flags, mask and summary alarm behind an apb slave
`timescale 1ns/100ps
`include "asm_map.vh"
module asm_alarm_top (
    input wire pclk, // 200 mhz clock
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [13:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped address
    input wire pll_locked, // pll lock level, asynchronous
    input wire link_enable, // link enabled, same clock
    input wire data_encoding_state, // link in data encoding state, same clock
    input wire realign_event, // one-cycle sysref realign pulse, same clock
    input wire [7:0] divider_a, // channel a divider phase, same clock
    input wire [7:0] divider_b, // channel b divider phase, same clock
    input wire [1:0] cal_status_sel, // calibration status pin source select
    input wire cal_status_in, // calibration done level from calibration logic
    output reg calibration_status_pin // calibration status output
);
    localparam [1:0] SEL_ALARM = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // condition capture
    wire pll_locked_s;
    asm_sync u_lock_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pll_locked),
        .dout(pll_locked_s)
    );

    wire [7:0] cond;
    assign cond[7:5] = 3'b000;
    assign cond[`ASM_BIT_LOCK] = ~pll_locked_s;
    assign cond[`ASM_BIT_LINK] = link_enable & ~data_encoding_state;
    assign cond[`ASM_BIT_REALIGN] = realign_event;
    assign cond[`ASM_BIT_OSC] = 1'b0;
    assign cond[`ASM_BIT_DIVIDER] = (divider_a != divider_b);

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire access = psel & penable & pready;
    wire [11:0] idx = paddr[13:2];
    wire word_ok = (paddr[1:0] == 2'b00);
    wire hit_alarm = word_ok && (idx == `ASM_IDX_ALARM);
    wire hit_status = word_ok && (idx == `ASM_IDX_STATUS);
    wire hit_mask = word_ok && (idx == `ASM_IDX_MASK);
    wire mapped = hit_alarm | hit_status | hit_mask;
    wire wr_status = access & pwrite & hit_status;
    wire wr_mask = access & pwrite & hit_mask;

    ////////////////////////////////////////////////////////////////////////
    // flags and mask
    reg [7:0] status_q;
    reg [7:0] status_d;
    reg [7:0] mask_q;
    reg alarm_q;
    wire alarm_d = |(status_d & ~mask_q & `ASM_STATUS_USED);

    always @* begin
        status_d = status_q;
        if (wr_status)
            status_d = status_d & ~pwdata[7:0];
        status_d = (status_d | cond) & `ASM_STATUS_USED;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `ASM_STATUS_RESET & `ASM_STATUS_USED;
            mask_q <= `ASM_MASK_RESET;
            alarm_q <= 1'b0;
            calibration_status_pin <= 1'b0;
        end else begin
            status_q <= status_d;
            if (wr_mask)
                mask_q <= pwdata[7:0] & `ASM_MASK_USED;
            alarm_q <= alarm_d;
            if (cal_status_sel == SEL_ALARM)
                calibration_status_pin <= alarm_d;
            else
                calibration_status_pin <= cal_status_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb response: one wait state, then ready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite) begin
                if (hit_alarm)
                    prdata <= {31'h0000_0000, alarm_q};
                else if (hit_status)
                    prdata <= {24'h00_0000, status_q};
                else if (hit_mask)
                    prdata <= {24'h00_0000, mask_q};
                else
                    prdata <= 32'h0000_0000;
            end else if (access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule // asm_alarm_top

// ===== sim/asm_alarm_props.sv
// port-level assertions for the alarm status and mask block
`timescale 1ns/100ps
module asm_alarm_props (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire psel, // select
    input wire penable, // access phase
    input wire pwrite, // direction
    input wire [13:0] paddr, // byte address
    input wire [31:0] prdata, // read data
    input wire pready, // ready
    input wire pslverr, // error
    input wire pll_locked, // lock level
    input wire [7:0] divider_a, // channel a divider
    input wire [7:0] divider_b, // channel b divider
    input wire [1:0] cal_status_sel, // pin source select
    input wire cal_status_in, // calibration level
    input wire calibration_status_pin // status pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_stat_rd;
        pready && !pwrite && paddr == 14'h0b04;
    endsequence
    a_one_wait_state: assert property (s_setup |-> ##1 !pready ##1 pready)
        else $error("ready not one wait state after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside ready");
    a_unmapped_err: assert property (pready && paddr[13:2] > 12'h02c2 |-> pslverr)
        else $error("no error on unmapped address");
    a_status_rsvd: assert property (s_stat_rd |-> prdata[31:5] == 0 && !prdata[1])
        else $error("status reserved bits not zero");
    a_lock_seen: assert property (!pll_locked [*6] ##0 s_stat_rd |-> prdata[4])
        else $error("lock lost flag not set");
    a_divider_seen: assert property ((divider_a != divider_b) [*3] ##0 s_stat_rd |-> prdata[0])
        else $error("divider flag not set");
    a_pin_pass: assert property (cal_status_sel != 2 |=> calibration_status_pin == $past(cal_status_in))
        else $error("pin does not follow calibration level");
endmodule // asm_alarm_props
bind asm_alarm_top asm_alarm_props u_props (.*);

// ===== sim/test_alarm_status_mask_logic.sv
// self-checking bench for the alarm status and mask block
`timescale 1ns/100ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module test_alarm_status_mask_logic;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pll_locked = 1;
    logic link_enable = 0, data_encoding_state = 0, realign_event = 0, cal_status_in = 0;
    logic pready, pslverr, calibration_status_pin, e;
    logic [13:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [7:0] divider_a = 0, divider_b = 0;
    logic [1:0] cal_status_sel = 0;
    int failures = 0, tests_run = 0;
    asm_alarm_top dut (.*);
    initial forever #2.5 pclk = ~pclk;
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rd(input logic [13:0] a, input logic [31:0] x, input string n);
        apb(0, a, 0);
        `CHK(n, x, r)
    endtask
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge pclk);
        failures++;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rd(14'h0b08, 32'h1f, "mask");
        rd(14'h0b04, 32'h1d, "status");
        apb(1, 14'h0b04, 32'h0);
        rd(14'h0b04, 32'h1d, "status");
        apb(1, 14'h0b04, 32'h1f);
        rd(14'h0b04, 32'h0, "status");
        realign_event <= 1;
        @(posedge pclk);
        realign_event <= 0;
        apb(1, 14'h0b08, 32'h04);
        rd(14'h0b04, 32'h04, "status");
        rd(14'h0b00, 32'h0, "summary");
        cal_status_sel <= 2;
        apb(1, 14'h0b08, 32'h0);
        rd(14'h0b00, 32'h1, "summary");
        `CHK("pin", 1'b1, calibration_status_pin)
        apb(1, 14'h0b04, 32'h1f);
        cal_status_sel <= 2'h1;
        cal_status_in <= 1'b0;
        pll_locked <= 1'b0;
        link_enable <= 1'b1;
        divider_b <= 8'h01;
        repeat (4) @(posedge pclk);
        `CHK("pin pass", 1'b0, calibration_status_pin)
        rd(14'h0b04, 32'h19, "status");
        apb(1, 14'h0b04, 32'h1f);
        rd(14'h0b04, 32'h19, "status");
        apb(1, 14'h0b08, 32'h1b);
        rd(14'h0b00, 32'h0, "summary");
        data_encoding_state <= 1'b1;
        apb(1, 14'h0b04, 32'h1f);
        rd(14'h0b04, 32'h11, "status");
        apb(0, 14'h0c00, 0);
        `CHK("error", 1'b1, e)
        tally_and_finish;
    end
endmodule // test_alarm_status_mask_logic
